// [src/i2cc_pkg.sv]
// Purpose: Shared constants and types for the I2C controller data path
// Assumes: 50 MHz ref_clk, AXI4-Lite register access
// Notes: Register byte offsets are fixed here for the whole block
package i2cc_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_COUNT = 8'h00;
   localparam logic [7:0] OFS_RX = 8'h04;
   localparam logic [7:0] OFS_ADDR = 8'h08;
   localparam logic [7:0] OFS_TX = 8'h0c;
   localparam logic [7:0] OFS_MODE = 8'h10;
   localparam logic [2:0] SEL_COUNT = 3'h0;
   localparam logic [2:0] SEL_RX = 3'h1;
   localparam logic [2:0] SEL_ADDR = 3'h2;
   localparam logic [2:0] SEL_TX = 3'h3;
   localparam logic [2:0] SEL_MODE = 3'h4;
   localparam logic [2:0] SEL_NONE = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [9:0] ADDR_RST = 10'h000;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [15:0] MODE_WMASK = 16'hefff;
   localparam logic [16:0] CNT_FULL = 17'h10000;
   localparam logic [3:0] WORD_BITS = 4'h8;
   localparam logic [4:0] WIDE_PREFIX = 5'h1e;
   localparam int FIFO_DEPTH = 8;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int T_QTR_NS = 2500;
   localparam int QTR_CYC = (T_QTR_NS * CLK_MHZ + 999) / 1000;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic force_nack;
      logic free_run;
      logic start_request;
      logic rsv12;
      logic stop_request;
      logic controller_sel;
      logic transmit_sel;
      logic wide_addr_sel;
      logic repeat_sel;
      logic loopback_sel;
      logic module_enable;
      logic start_byte_sel;
      logic raw_format;
      logic [2:0] bits_per_word;
   } i2cc_mode_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_LOAD, ST_BIT, ST_ACK, ST_HOLD, ST_STOP
   } i2cc_state_t;
   typedef enum logic [1:0] {SEG_ADDR1, SEG_ADDR2, SEG_DATA} i2cc_seg_t;
endpackage

// [src/i2cc_top.sv]
// Purpose: I2C controller count, address and data registers with bus engine
// Assumes: AXI4-Lite master, open-drain pins resolved outside
// Notes: Transmit words pass an 8-word FIFO; full FIFO stalls the bus write
//
// Overview of operation
// - A zero count loads 65536 into the internal down-counter.
// - A nonzero count loads exactly that value into the down-counter.
// - Count gives words in non-repeat mode; repeat mode ignores it.
// - With stop requested, a STOP follows once the counter reaches zero.
// - Receive data holds up to 8 bits, right-aligned for shorter words.
// - Bits from SDA shift in, complete word copies to receive data.
// - Shift registers are hidden; only data registers are visible.
// - Written transmit word goes to the shift register and out on SDA.
// - Narrow addressing sends address bits 6-0, ignoring 9-7.
// - Wide addressing sends all address bits 9-0.
// - Address zero is a general call, nonzero names one target.
// - Without raw format, transfers begin with the target address.
// - Reserved bits read zero and ignore writes.
// - Mode register: nack bit 15, start 13, stop 11, all reset zero.
// - Each data word decrements the counter unless repeat is on; the count register stays.
// - The count applies only as controller with repeat off.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns

module i2cc_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clr,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp, rp;
   logic [AW:0] cnt;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt != (AW+1)'(D));
   assign out_valid = (cnt != '0);
   assign out_data = mem[rp];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else if (clr) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         if (push) wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
         if (pop) rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
         cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge clk) begin
      if (push) mem[wp] <= in_data;
   end
endmodule // i2cc_fifo

module i2cc_top (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);
   import i2cc_pkg::*;

   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      case (a)
         OFS_COUNT: reg_sel = SEL_COUNT;
         OFS_RX: reg_sel = SEL_RX;
         OFS_ADDR: reg_sel = SEL_ADDR;
         OFS_TX: reg_sel = SEL_TX;
         OFS_MODE: reg_sel = SEL_MODE;
         default: reg_sel = SEL_NONE;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] scl_sy, sda_sy;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         scl_sy <= 2'h3;
         sda_sy <= 2'h3;
      end else begin
         scl_sy <= {scl_sy[0], scl_i};
         sda_sy <= {sda_sy[0], sda_i};
      end
   end
   wire scl_s = scl_sy[1];
   wire sda_s = sda_sy[1];

   // ----------------------------------------------------------------
   // Registers and AXI4-Lite slave
   // ----------------------------------------------------------------
   logic [15:0] count_value;
   logic [9:0] target_addr;
   logic [7:0] tx_data_reg, rx_data_reg;
   i2cc_mode_t mode, next_mode;
   logic aw_got, w_got;
   logic [7:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   logic [31:0] rv [8];
   logic fifo_in_ready, fifo_valid, tx_pop;
   logic [7:0] fifo_out;
   logic start_done, stop_done, nack_clr;

   // Shift registers are never on this map reserved bits read 0
   assign rv[SEL_COUNT] = {16'h0, count_value};
   assign rv[SEL_RX] = {24'h0, rx_data_reg};
   assign rv[SEL_ADDR] = {22'h0, target_addr};
   assign rv[SEL_TX] = {24'h0, tx_data_reg};
   assign rv[SEL_MODE] = {16'h0, mode};
   for (genvar i = 5; i < 8; i++) begin : g_rv_zero
      assign rv[i] = 32'h0;
   end

   wire [2:0] wsel = reg_sel(wa);
   wire [2:0] rsel = reg_sel(araddr[7:0]);
   wire wr_tx = (wsel == SEL_TX);
   // A transmit write waits for FIFO room so the bus master is stalled
   wire commit = aw_got && w_got && !bvalid && (!wr_tx || fifo_in_ready);
   wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
   wire [31:0] wval = (rv[wsel] & ~wmask) | (wd & wmask);
   wire mode_wr = commit && (wsel == SEL_MODE);
   wire tx_push = commit && wr_tx;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         wa <= 8'h00;
         wd <= 32'h0;
         ws <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_got <= 1'b1;
            awready <= 1'b0;
            wa <= awaddr[7:0];
         end
         if (wvalid && wready) begin
            w_got <= 1'b1;
            wready <= 1'b0;
            wd <= wdata;
            ws <= wstrb;
         end
         if (commit) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b1;
            bresp <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rv[rsel];
         rresp <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Software writes win over a hardware clear in the same cycle
   always_comb begin
      next_mode = mode;
      if (start_done) next_mode.start_request = 1'b0;
      if (stop_done) begin
         next_mode.stop_request = 1'b0;
         next_mode.controller_sel = 1'b0;
      end
      if (nack_clr) next_mode.force_nack = 1'b0;
      if (mode_wr) next_mode = i2cc_mode_t'(wval[15:0] & MODE_WMASK);
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mode <= i2cc_mode_t'(MODE_RST);
         count_value <= COUNT_RST;
         target_addr <= ADDR_RST;
         tx_data_reg <= DATA_RST;
      end else begin
         mode <= next_mode;
         if (commit && wsel == SEL_COUNT) count_value <= wval[15:0];
         if (commit && wsel == SEL_ADDR) target_addr <= wval[9:0];
         if (tx_push) tx_data_reg <= wval[7:0];
      end
   end

   i2cc_fifo #(.W(8), .D(FIFO_DEPTH)) u_txq (
      .clk(ref_clk),
      .rstn(rstn),
      .clr(!mode.module_enable),
      .in_valid(tx_push),
      .in_data(wval[7:0]),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_valid),
      .out_ready(tx_pop),
      .out_data(fifo_out)
   );

   // ----------------------------------------------------------------
   // Bus engine
   // ----------------------------------------------------------------
   i2cc_state_t state, next_state;
   i2cc_seg_t seg;
   logic [1:0] phase, next_phase;
   logic [7:0] qcnt, sh;
   logic [3:0] nbit;
   logic [16:0] dcnt;
   logic bus_own, quit, next_scl_low, next_sda_low;

   wire en = mode.module_enable;
   wire tick = (qcnt == 8'(QTR_CYC - 1));
   // Waiting for released SCL to read high lets targets stretch the clock
   wire hold = scl_oe_n && !scl_s;
   wire ph3 = tick && (phase == 2'h3);
   wire [3:0] n_bits = (mode.bits_per_word == 3'h0) ? WORD_BITS : {1'b0, mode.bits_per_word};
   wire is_data = (seg == SEG_DATA);
   wire is_rx_data = is_data && !mode.transmit_sel;
   wire last_word = !mode.repeat_sel && (dcnt == 17'h0);
   wire send_nack = is_rx_data && (mode.force_nack || (!mode.repeat_sel && dcnt == 17'h1));
   wire go_stop = quit || (is_data && last_word && mode.stop_request);
   wire go_hold = is_data && last_word && !mode.stop_request;
   wire stall = is_data && mode.transmit_sel && !fifo_valid;
   wire load_go = (state == ST_LOAD) && tick && !go_stop && !go_hold && !stall;
   wire rd_bit = !mode.transmit_sel;
   // Narrow mode sends bits 6-0 only; wide mode sends prefix, 9-8, then 7-0
   wire [7:0] addr1 = mode.wide_addr_sel ? {WIDE_PREFIX, target_addr[9:8], rd_bit}
                                         : {target_addr[6:0], rd_bit};
   wire [7:0] tx_aligned = 8'(fifo_out << (WORD_BITS - n_bits));
   wire [7:0] load_val = (seg == SEG_ADDR1) ? addr1 :
                         (seg == SEG_ADDR2) ? target_addr[7:0] : tx_aligned;
   wire bit_done = (state == ST_BIT) && ph3 && (nbit == 4'h1);
   wire rx_done = bit_done && is_rx_data;
   wire ack_done = (state == ST_ACK) && ph3;
   wire word_done = ack_done && is_data;
   assign start_done = (state == ST_START) && ph3;
   assign stop_done = (state == ST_STOP) && ph3;
   assign nack_clr = ack_done && is_rx_data && mode.force_nack;
   assign tx_pop = load_go && is_data && mode.transmit_sel;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: if (mode.start_request && mode.controller_sel) next_state = ST_START;
         ST_START: if (ph3) next_state = ST_LOAD;
         ST_LOAD: begin
            if (tick && go_stop) next_state = ST_STOP;
            else if (tick && go_hold) next_state = ST_HOLD;
            else if (load_go) next_state = ST_BIT;
         end
         ST_BIT: if (bit_done) next_state = ST_ACK;
         ST_ACK: if (ph3) next_state = ST_LOAD;
         ST_HOLD: begin
            if (tick && mode.start_request) next_state = ST_START;
            else if (tick && mode.stop_request) next_state = ST_STOP;
         end
         ST_STOP: if (ph3) next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   wire multi = (state == ST_START) || (state == ST_BIT) || (state == ST_ACK)
                || (state == ST_STOP);
   assign next_phase = (next_state != state) ? 2'h0 : (multi && tick) ? phase + 2'h1 : phase;

   // Pin drive, SDA only changes while SCL is low except in START and STOP
   always_comb begin
      next_scl_low = 1'b0;
      next_sda_low = 1'b0;
      case (state)
         ST_IDLE: next_sda_low = 1'b0;
         ST_START: begin
            next_scl_low = (phase == 2'h0) && bus_own;
            next_sda_low = phase[1];
         end
         ST_LOAD, ST_HOLD: begin
            next_scl_low = 1'b1;
            next_sda_low = !sda_oe_n;
         end
         // SDA keeps its level through the first low quarter, never moving with the SCL fall
         ST_BIT: begin
            next_scl_low = !phase[1];
            next_sda_low = (phase == 2'h0) ? !sda_oe_n : (!is_rx_data && !sh[7]);
         end
         ST_ACK: begin
            next_scl_low = !phase[1];
            next_sda_low = (phase == 2'h0) ? !sda_oe_n : (is_rx_data && !send_nack);
         end
         ST_STOP: begin
            next_scl_low = !phase[1];
            next_sda_low = (phase != 2'h3);
         end
         default: next_scl_low = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         phase <= 2'h0;
         qcnt <= 8'h00;
         bus_own <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else if (!en) begin
         state <= ST_IDLE;
         phase <= 2'h0;
         qcnt <= 8'h00;
         bus_own <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
      end else begin
         state <= next_state;
         phase <= next_phase;
         qcnt <= (state == ST_IDLE || tick) ? 8'h00 : hold ? qcnt : qcnt + 8'h01;
         if (start_done) bus_own <= 1'b1;
         else if (stop_done) bus_own <= 1'b0;
         scl_oe_n <= !next_scl_low;
         sda_oe_n <= !next_sda_low;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         seg <= SEG_ADDR1;
         sh <= 8'h00;
         nbit <= 4'h0;
         dcnt <= 17'h0;
         quit <= 1'b0;
         rx_data_reg <= DATA_RST;
      end else begin
         if (start_done) begin
            seg <= mode.raw_format ? SEG_DATA : SEG_ADDR1;
            quit <= 1'b0;
            dcnt <= (count_value == 16'h0) ? CNT_FULL : {1'b0, count_value};
         end
         if (load_go) begin
            sh <= load_val;
            nbit <= is_data ? n_bits : WORD_BITS;
         end else if ((state == ST_BIT) && ph3) begin
            sh <= {sh[6:0], sda_s};
            nbit <= nbit - 4'h1;
         end
         if (rx_done) rx_data_reg <= {sh[6:0], sda_s};
         if (ack_done) begin
            quit <= (!is_rx_data && sda_s) || (is_data && mode.repeat_sel && mode.stop_request);
            if (seg == SEG_ADDR1) seg <= mode.wide_addr_sel ? SEG_ADDR2 : SEG_DATA;
            else seg <= SEG_DATA;
         end
         if (word_done && !mode.repeat_sel) dcnt <= dcnt - 17'h1;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_load_zero: assert property (start_done && count_value == 16'h0 |=> dcnt == 17'h10000)
      else $error("zero count did not load 65536");
   a_load_value: assert property (start_done && count_value != 16'h0
                                  |=> dcnt == {1'b0, $past(count_value)})
      else $error("nonzero count not loaded");
   a_repeat_hold: assert property (word_done && mode.repeat_sel |=> $stable(dcnt))
      else $error("counter moved in repeat mode");
   a_stop_zero: assert property (state == ST_LOAD && tick && is_data && last_word
                                 && mode.stop_request && en |=> state == ST_STOP)
      else $error("no stop at zero count");
   a_rx_copy: assert property (rx_done |=> rx_data_reg[0] == $past(sda_s))
      else $error("received word not copied");
   a_tx_shift: assert property (tx_pop |=> sh == $past(tx_aligned))
      else $error("transmit word not loaded");
   a_addr_narrow: assert property (load_go && seg == SEG_ADDR1 && !mode.wide_addr_sel
                                   |=> sh[7:1] == $past(target_addr[6:0]))
      else $error("narrow address bits wrong");
   a_addr_wide: assert property (load_go && seg == SEG_ADDR2 |=> sh == $past(target_addr[7:0]))
      else $error("wide address low byte wrong");
   // Only a software write may move the count register while the counter steps
   a_count_dec: assert property (word_done && !mode.repeat_sel
                                 |=> dcnt == $past(dcnt) - 17'h1
                                 && (count_value == $past(count_value)
                                 || $past(commit && wsel == SEL_COUNT)))
      else $error("counter did not step by one");
   a_resv_zero: assert property (rvalid |-> rdata[31:16] == 16'h0)
      else $error("reserved bits read nonzero");
   a_start_clear: assert property (start_done && !mode_wr |=> !mode.start_request)
      else $error("start request not cleared");

   c_stop_seen: cover property (state == ST_STOP ##1 state == ST_STOP [*3] ##[1:500] state == ST_IDLE);
   c_rx_word: cover property (rx_done);
   c_fifo_full: cover property (aw_got && w_got && wr_tx && !fifo_in_ready);
   c_hold_seen: cover property (state == ST_HOLD);
endmodule // i2cc_top

// [test/i2cc_target_model.sv]
// Purpose: I2C target model for the controller bench
// Assumes: SCL comes from the controller, SDA is open drain with a pull-up
// Notes: Acks every byte it is sent and logs every byte seen on SDA
`timescale 1ns/1ns
module i2cc_target_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic [7:0] rd_byte,
   output logic sda_oe_n
);
   logic [7:0] got[$];
   logic [7:0] sh = 8'h00;
   logic rd_dir = 1'b0;
   logic first = 1'b0;
   int bitn = 0;
   initial sda_oe_n = 1'b1;
   // ----------------------------------------
   // Framing
   // ----------------------------------------
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         bitn = 0;
         first = 1'b1;
      end
   end
   // A read NACK makes the model let go, or it would block the STOP
   always @(posedge scl) begin
      if (bitn < 8) sh = {sh[6:0], sda};
      if (bitn == 8 && rd_dir && !first && sda) rd_dir = 1'b0;
      bitn = bitn + 1;
      if (bitn == 8) begin
         got.push_back(sh);
         if (first) rd_dir = sh[0];
      end
   end
   always @(negedge scl) begin
      if (bitn == 8) begin
         sda_oe_n = rd_dir && !first;
      end else if (bitn == 9) begin
         bitn = 0;
         first = 1'b0;
         sda_oe_n = rd_dir ? rd_byte[7] : 1'b1;
      end else if (bitn > 0 && bitn < 8 && rd_dir && !first) begin
         sda_oe_n = rd_byte[7-bitn];
      end
   end
endmodule // i2cc_target_model

// [test/i2cc_top_tb.sv]
// Purpose: Self-checking bench for the I2C count, address and data registers
// Assumes: AXI4-Lite master tasks, target model on the open-drain pins
// Notes: Expected wire bytes are queued from the programmed values
`timescale 1ns/1ns
module i2cc_top_tb;
   import i2cc_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, v, d;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe_n, sda_o, sda_oe_n, tgt_oe_n;
   logic [1:0] bresp, rresp, r;
   logic [7:0] rd_byte = 8'h00, b1, b2;
   logic [7:0] exp_q[$];
   integer seed = 32'hbad429b8;
   int bad_count = 0;
   int compares = 0;
   int n;
   logic [7:0] ofs[5] = '{OFS_COUNT, OFS_RX, OFS_ADDR, OFS_TX, OFS_MODE};
   logic [31:0] msk[5] = '{32'hffff, 32'h0, 32'h3ff, 32'hff, 32'hefff};
   wire scl = scl_oe_n ? 1'b1 : scl_o;
   wire sda = (sda_oe_n ? 1'b1 : sda_o) & tgt_oe_n;
   always #10 ref_clk = ~ref_clk;
   i2cc_top u_i2cc_top (.ref_clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .scl_i(scl), .scl_o, .scl_oe_n, .sda_i(sda), .sda_o, .sda_oe_n);
   i2cc_target_model u_i2cc_target_model (.scl(scl), .sda(sda), .rd_byte(rd_byte),
      .sda_oe_n(tgt_oe_n));
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dv);
      @(posedge ref_clk);
      awaddr <= {24'h0, a};
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(d, exp);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
   endtask
   // Program address and count, start, wait for the STOP, then compare the wire
   task automatic run(input logic [9:0] a, input logic [15:0] c, input logic [15:0] m,
         input logic [31:0] after);
      wr(OFS_ADDR, {22'h0, a});
      wr(OFS_COUNT, {16'h0, c});
      wr(OFS_MODE, {16'h0, m});
      n = 0;
      do begin
         repeat (50) @(posedge ref_clk);
         rd(OFS_MODE);
         n++;
      end while (d[10] && n < 1000);
      chk({31'h0, d[10]}, 32'h0);
      chk(u_i2cc_target_model.got.size(), exp_q.size());
      foreach (exp_q[i]) chk(u_i2cc_target_model.got[i], exp_q[i]);
      exp_q = {};
      u_i2cc_target_model.got = {};
      rchk(OFS_COUNT, {16'h0, c});
      rchk(OFS_MODE, after);
      chk({30'h0, sda, scl}, 32'h3);
   endtask
   task automatic end_of_test;
      if (bad_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      foreach (ofs[i]) rchk(ofs[i], 32'h0);
      // Enable kept low so random mode values cannot launch a transfer
      foreach (ofs[i]) begin
         v = $random(seed) & ~32'h20;
         wr(ofs[i], v);
         chk({30'h0, r}, {30'h0, RESP_OKAY});
         rchk(ofs[i], v & msk[i]);
      end
      wr(8'h14, 32'hffffffff);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd(8'h14);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(OFS_MODE, 32'h20);
      b1 = 8'($random(seed));
      b2 = 8'($random(seed));
      wr(OFS_TX, {24'h0, b1});
      wr(OFS_TX, {24'h0, b2});
      exp_q = '{8'h00, b1, b2};
      run(10'h380, 16'h2, 16'h2e20, 32'h0220);
      wr(OFS_TX, {24'h0, b2});
      exp_q = '{8'hf4, 8'hb7, b2};
      run(10'h2b7, 16'h1, 16'h2f20, 32'h0320);
      // Repeat mode with stop ends after one word whatever the count says
      wr(OFS_TX, {24'h0, b1});
      exp_q = '{8'h46, b1};
      run(10'h123, 16'h3, 16'h2ea0, 32'h02a0);
      // Raw format sends no address; low bit 0 keeps the target writing
      wr(OFS_TX, 32'h3c);
      exp_q = '{8'h3c};
      run(10'h3ff, 16'h1, 16'h2e28, 32'h0228);
      rd_byte <= b1;
      exp_q = '{8'hb5, b1};
      run(10'h05a, 16'h1, 16'h2c20, 32'h0020);
      rchk(OFS_RX, {24'h0, b1});
      end_of_test;
   end
   initial begin
      #2000000;
      bad_count++;
      end_of_test;
   end
endmodule // i2cc_top_tb
